// file: tic_pkg_sync.sv
// Constants for the time interval counter, plus its pin synchroniser.
// Assumes one clock; pins are asynchronous to it.
package tic_pkg;
	localparam int TIC_AW = 4;
	localparam int TIC_DW = 32;
	localparam logic [TIC_AW-1:0] OFS_CTRL = 4'h0;
	localparam logic [TIC_AW-1:0] OFS_STATUS = 4'h4;
	localparam logic [TIC_AW-1:0] OFS_RESULT = 4'h8;
	localparam logic [TIC_AW-1:0] OFS_COUNT = 4'hC;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_TIMING = 3;
	localparam int CTRL_WIDTH_EDGE = 5;
	localparam int CTRL_START_EDGE = 6;
	localparam int CTRL_END_EDGE = 7;
	localparam int CTRL_ARM_EN = 8;
	localparam int CTRL_ARM_POL = 9;
	localparam int CTRL_DECODE = 10;
	localparam int CTRL_ARM_SRC = 12;
	localparam int CTRL_TB_SRC = 14;
	localparam int CTRL_SMP_SRC = 16;
	localparam int CTRL_BITS = 18;
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 18'h0;
	localparam int STAT_ARMED = 0;
	localparam int STAT_VALID = 1;
	localparam int STAT_OVERFLOW = 2;
	localparam int STAT_MEASURING = 3;
	localparam int ONBOARD_TB_HZ = 100_000_000;
	localparam int CLK_HZ = 100_000_000;
	typedef enum logic [1:0] {
		MODE_WIDTH = 2'b00,
		MODE_TWO_EDGE = 2'b01,
		MODE_QUAD = 2'b10,
		MODE_OFF = 2'b11
	} tic_mode_t;
	typedef enum logic [1:0] {
		TIM_ON_DEMAND = 2'b00,
		TIM_IMPLICIT = 2'b01,
		TIM_SAMPLE = 2'b10,
		TIM_RSVD = 2'b11
	} tic_timing_t;
	typedef enum logic [1:0] {
		DEC_SINGLE = 2'b00,
		DEC_DOUBLE = 2'b01,
		DEC_QUAD = 2'b10,
		DEC_RSVD = 2'b11
	} tic_decode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_MEAS = 2'b10,
		ST_HOLD = 2'b11
	} tic_state_t;
endpackage : tic_pkg

`timescale 1ns/1ps
`default_nettype none

module tic_pin_sync #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Pins
	input wire logic [N-1:0] pin_i,
	// Synchronised level and edges
	output logic [N-1:0] lvl_o,
	output logic [N-1:0] rise_o,
	output logic [N-1:0] fall_o
);
	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;

	// Two stages, then a history stage for edges
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (ce_i) begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign lvl_o = s2_q;
	assign rise_o = s2_q & ~s3_q;
	assign fall_o = ~s2_q & s3_q;
endmodule : tic_pin_sync

`default_nettype wire

// file: tic_counter.sv
// Time interval counter: pulse width, two-edge separation, quadrature.
// Assumes a plain register port and pins asynchronous to clk_i.
// What this block does
// - Width counts timebase edges while input active
// - Partial pulse at arming is ignored
// - Default measures high pulse, rise to fall
// - Starting edge selects high or low pulse
// - On-demand width: hold result until read
// - Implicit width: buffer every pulse
// - Sample clock stores latest complete width
// - Start by software or arm trigger edge
// - Trigger during active input: next full pulse
// - Timebase selectable, onboard clock by default
// - Two-edge: first input edge to second
// - Both edges rising by default, independently set
// - On-demand two-edge: hold interval until read
// - Implicit two-edge: buffer every pair
// - Sample clock stores latest complete pair
// - Quadrature counts up A leads, down B
// - Steps per cycle set by decode type
// - Single on A, double both A, quad all
`timescale 1ns/1ps
`default_nettype none

module tic_counter
	import tic_pkg::*;
#(
	parameter int NPFI = 4,
	parameter int FIFO_DEPTH = 8,
	parameter int CNT_W = TIC_DW
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Register port
	input wire logic [TIC_AW-1:0] addr_i,
	input wire logic [TIC_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [TIC_DW-1:0] rdata_o,
	// Function input pins
	input wire logic [NPFI-1:0] programmable_function_input_i
);
	localparam int PW = $clog2(FIFO_DEPTH);

	initial begin
		if (NPFI < 3 || NPFI > 4 || CNT_W != TIC_DW || FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin
			$error("tic_counter: unsupported parameters");
		end
	end

	logic [NPFI-1:0] pin_lvl;
	logic [NPFI-1:0] pin_rise;
	logic [NPFI-1:0] pin_fall;

	tic_pin_sync #(.N(NPFI)) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.pin_i(programmable_function_input_i),
		.lvl_o(pin_lvl),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	logic [CTRL_BITS-1:0] ctrl_q;
	logic armed_q;
	logic ovf_q;
	tic_state_t state_q;
	tic_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] result_q;
	logic [CNT_W-1:0] latest_q;
	logic latest_vld_q;
	logic [CNT_W-1:0] pos_q;
	logic [TIC_DW-1:0] rdata_q;
	logic [CNT_W-1:0] mem [FIFO_DEPTH];
	logic [PW:0] wp_q;
	logic [PW:0] rp_q;

	// Configuration decode
	wire tic_mode_t mode = tic_mode_t'(ctrl_q[CTRL_MODE +: 2]);
	wire tic_timing_t timing = tic_timing_t'(ctrl_q[CTRL_TIMING +: 2]);
	wire tic_decode_t decode = tic_decode_t'(ctrl_q[CTRL_DECODE +: 2]);
	wire logic run = ctrl_q[CTRL_RUN];
	wire logic width_start_edge_select = ctrl_q[CTRL_WIDTH_EDGE];
	wire logic start_event_edge_select = ctrl_q[CTRL_START_EDGE];
	wire logic end_event_edge_select = ctrl_q[CTRL_END_EDGE];
	wire logic arm_en = ctrl_q[CTRL_ARM_EN];
	wire logic arm_trigger_polarity = ctrl_q[CTRL_ARM_POL];
	wire logic [1:0] arm_trigger_source = ctrl_q[CTRL_ARM_SRC +: 2];
	wire logic [1:0] timebase_source_select = ctrl_q[CTRL_TB_SRC +: 2];
	wire logic [1:0] smp_src = ctrl_q[CTRL_SMP_SRC +: 2];

	// Edge of the chosen polarity on a pin
	function automatic logic pick_edge(input logic [1:0] sel, input logic fall_sel,
			input logic [NPFI-1:0] rise, input logic [NPFI-1:0] fall);
		pick_edge = fall_sel ? fall[sel] : rise[sel];
	endfunction : pick_edge

	// Register port decode
	wire logic ctrl_wr = ce_i && wr_i && addr_i == OFS_CTRL;
	wire logic cnt_wr = ce_i && wr_i && addr_i == OFS_COUNT;
	wire logic rd_result = ce_i && rd_i && addr_i == OFS_RESULT;

	wire logic tb_tick = (timebase_source_select == 2'b00) ? 1'b1
		: pin_rise[timebase_source_select];
	wire logic trig_ev = pick_edge(arm_trigger_source, arm_trigger_polarity, pin_rise, pin_fall);
	wire logic smp_ev = pin_rise[smp_src];
	wire logic active = armed_q && run;

	// input 0 rising starts by default
	wire logic w_start = width_start_edge_select ? pin_fall[0] : pin_rise[0];
	wire logic w_end = width_start_edge_select ? pin_rise[0] : pin_fall[0];
	wire logic e_start = pick_edge(2'b00, start_event_edge_select, pin_rise, pin_fall);
	wire logic e_end = pick_edge(2'b01, end_event_edge_select, pin_rise, pin_fall);
	wire logic start_ev = (mode == MODE_WIDTH) ? w_start : (mode == MODE_TWO_EDGE) && e_start;
	wire logic end_ev = (mode == MODE_WIDTH) ? w_end : (mode == MODE_TWO_EDGE) && e_end;

	wire logic [CNT_W-1:0] meas_val = cnt_q + CNT_W'(tb_tick);
	wire logic done = ce_i && active && state_q == ST_MEAS && end_ev;
	wire logic restart = done && start_ev && timing != TIM_ON_DEMAND;

	// Buffer control
	wire logic [PW:0] fill = wp_q - rp_q;
	wire logic empty = fill == '0;
	wire logic full = fill == (PW+1)'(FIFO_DEPTH);
	wire logic buffered = timing == TIM_IMPLICIT || timing == TIM_SAMPLE;
	wire logic pop = rd_result && buffered && !empty;
	wire logic push_imp = done && timing == TIM_IMPLICIT;
	wire logic push_smp = ce_i && active && timing == TIM_SAMPLE && smp_ev
		&& (mode == MODE_QUAD || latest_vld_q);
	wire logic push_req = (push_imp || push_smp) && !ctrl_wr;
	wire logic push = push_req && !full;
	wire logic [CNT_W-1:0] push_val = push_imp ? meas_val
		: (mode == MODE_QUAD) ? pos_q : latest_q;

	// decode type sets steps per cycle
	wire logic a_lv = pin_lvl[0];
	wire logic b_lv = pin_lvl[1];
	wire logic up1 = pin_rise[0] && !b_lv;
	wire logic dn1 = pin_fall[0] && !b_lv;
	wire logic up2 = up1 || (pin_fall[0] && b_lv);
	wire logic dn2 = dn1 || (pin_rise[0] && b_lv);
	wire logic up4 = up2 || (pin_rise[1] && a_lv) || (pin_fall[1] && !a_lv);
	wire logic dn4 = dn2 || (pin_rise[1] && !a_lv) || (pin_fall[1] && a_lv);
	wire logic q_up = (decode == DEC_SINGLE) ? up1 : (decode == DEC_DOUBLE) ? up2
		: (decode == DEC_QUAD) && up4;
	wire logic q_dn = (decode == DEC_SINGLE) ? dn1 : (decode == DEC_DOUBLE) ? dn2
		: (decode == DEC_QUAD) && dn4;
	wire logic q_step = active && mode == MODE_QUAD && (q_up != q_dn);

	// Measurement sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (active && mode != MODE_QUAD && mode != MODE_OFF) begin
					state_d = ST_WAIT;
				end
			end
			// only a fresh start edge begins
			ST_WAIT: begin
				if (start_ev) begin
					state_d = ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (end_ev) begin
					state_d = (timing == TIM_ON_DEMAND) ? ST_HOLD : restart ? ST_MEAS : ST_WAIT;
				end
			end
			ST_HOLD: begin
				if (rd_result) begin
					state_d = ST_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= CTRL_RESET;
			armed_q <= 1'b0;
			state_q <= ST_IDLE;
		end else if (ce_i) begin
			if (ctrl_wr) begin
				ctrl_q <= wdata_i[CTRL_BITS-1:0];
				armed_q <= 1'b0;
				state_q <= ST_IDLE;
			end else begin
				if (run && !armed_q && (!arm_en || trig_ev)) begin
					armed_q <= 1'b1;
				end
				state_q <= active ? state_d : ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			if (state_q != ST_MEAS || restart) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= meas_val;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result_q <= '0;
			latest_q <= '0;
			latest_vld_q <= 1'b0;
		end else if (ce_i) begin
			if (done && timing == TIM_ON_DEMAND) begin
				result_q <= meas_val;
			end
			if (ctrl_wr) begin
				latest_vld_q <= 1'b0;
			end else if (done) begin
				latest_q <= meas_val;
				latest_vld_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos_q <= '0;
		end else if (cnt_wr) begin
			pos_q <= wdata_i;
		end else if (ce_i && q_step) begin
			pos_q <= q_up ? pos_q + CNT_W'(1) : pos_q - CNT_W'(1);
		end
	end

	// Result buffer; overflow drops and flags
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_q[PW-1:0]] <= push_val;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
			ovf_q <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_wr) begin
				wp_q <= '0;
				rp_q <= '0;
				ovf_q <= 1'b0;
			end else begin
				wp_q <= push ? wp_q + (PW+1)'(1) : wp_q;
				rp_q <= pop ? rp_q + (PW+1)'(1) : rp_q;
				ovf_q <= ovf_q || (push_req && full);
			end
		end
	end

	// Read data mux
	wire logic valid = (timing == TIM_ON_DEMAND) ? state_q == ST_HOLD : !empty;
	wire logic [CNT_W-1:0] head = empty ? '0 : mem[rp_q[PW-1:0]];
	wire logic [TIC_DW-1:0] status_word = {28'h0, state_q == ST_MEAS, ovf_q, valid, armed_q};
	wire logic [TIC_DW-1:0] rd_mux = (addr_i == OFS_CTRL) ? {14'h0, ctrl_q}
		: (addr_i == OFS_STATUS) ? status_word
		: (addr_i == OFS_RESULT) ? (buffered ? head : result_q)
		: (addr_i == OFS_COUNT) ? pos_q : 32'h0;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= '0;
		end else if (ce_i) begin
			rdata_q <= rd_i ? rd_mux : 32'h0;
		end
	end

	assign rdata_o = rdata_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	width_tick_count_a: assert property (
		ce_i && state_q == ST_MEAS && !end_ev && tb_tick |=> cnt_q == $past(cnt_q) + 32'h1)
		else $error("tick not counted");
	partial_pulse_skip_a: assert property (
		ce_i && !ctrl_wr && state_q == ST_WAIT && !start_ev |=> state_q != ST_MEAS)
		else $error("measure began without start edge");
	high_pulse_default_a: assert property (
		ce_i && mode == MODE_WIDTH && !width_start_edge_select && state_q == ST_WAIT && start_ev
		|-> pin_lvl[0]) else $error("default pulse not high");
	low_pulse_select_a: assert property (
		ce_i && mode == MODE_WIDTH && width_start_edge_select && state_q == ST_WAIT && start_ev
		|-> !pin_lvl[0]) else $error("low pulse start wrong");
	hold_until_read_a: assert property (
		ce_i && !ctrl_wr && state_q == ST_HOLD && !rd_result |=> state_q == ST_HOLD && $stable(result_q))
		else $error("held result lost before read");
	implicit_push_a: assert property (
		done && timing == TIM_IMPLICIT && !ctrl_wr && !full && !pop |=> fill == $past(fill) + 4'h1)
		else $error("implicit result not buffered");
	sample_store_a: assert property (
		push_smp && !ctrl_wr && !full && !pop && mode != MODE_QUAD
		|=> fill == $past(fill) + 4'h1 && mem[$past(wp_q[PW-1:0])] == $past(latest_q))
		else $error("sample edge did not store latest");
	arm_wait_a: assert property (
		ce_i && arm_en && !armed_q && !trig_ev && !ctrl_wr |=> !armed_q)
		else $error("armed without trigger");
	two_edge_hold_a: assert property (
		ce_i && mode == MODE_TWO_EDGE && state_q == ST_HOLD && !rd_result && !ctrl_wr
		|=> state_q == ST_HOLD) else $error("two-edge hold broken");
	quad_up_step_a: assert property (
		ce_i && !cnt_wr && active && mode == MODE_QUAD && decode == DEC_SINGLE && pin_rise[0] && !pin_lvl[1]
		|=> pos_q == $past(pos_q) + 32'h1) else $error("quadrature up step missed");

	width_done_c: cover property (done && mode == MODE_WIDTH);
	two_edge_done_c: cover property (done && mode == MODE_TWO_EDGE && timing == TIM_IMPLICIT);
	sample_push_c: cover property (push_smp && push);
	overflow_c: cover property (push_req && full);
endmodule : tic_counter

`default_nettype wire

// file: tic_pin_model.sv
// Far-side pin driver: pulses, edge pairs, encoder, timebase.
// Assumes pins are sampled on rising edges of clk_i.
`timescale 1ns/1ps
`default_nettype none
module tic_pin_model (
	// Clock
	input wire logic clk_i,
	// Pins
	output var logic [3:0] pin_o
);
	logic tb_on;
	initial begin
		pin_o = 4'h0;
		tb_on = 1'b0;
	end
	// External timebase on pin 3
	always @(posedge clk_i) begin
		if (tb_on) begin
			pin_o[3] <= ~pin_o[3];
		end
	end
	task automatic run_tb(input logic on);
		@(posedge clk_i);
		tb_on <= on;
	endtask : run_tb
	task automatic set(input int i, input logic v);
		@(posedge clk_i);
		pin_o[i] <= v;
	endtask : set
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold
	task automatic pulse(input int i, input logic a, input int n);
		set(i, a);
		hold(n);
		pin_o[i] <= ~a;
	endtask : pulse
	task automatic pair(input logic s, input logic e, input int n);
		set(0, ~s);
		hold(n);
		pin_o[1] <= ~e;
		hold(4);
		pin_o[0] <= s;
		pin_o[1] <= e;
	endtask : pair
	task automatic quad(input logic fwd, input int c);
		logic [1:0] g[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
		repeat (c) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_i);
				pin_o[1:0] <= fwd ? g[k] : {g[k][0], g[k][1]};
				hold(4);
			end
		end
	endtask : quad
endmodule : tic_pin_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the time interval counter.
// Assumes the pin model on pins 0..3 and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tic_pkg::*;
;
	typedef struct {logic [31:0] c; int n;} tic_row_t;
	logic clk_i;
	logic arst_n_i;
	logic ce_i;
	logic [TIC_AW-1:0] addr_i;
	logic [TIC_DW-1:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [TIC_DW-1:0] rdata_o;
	logic [3:0] pin;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	tic_row_t rows[8];

	always #5 clk_i = ~clk_i;

	tic_counter u_tic_counter (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.programmable_function_input_i(pin)
	);
	tic_pin_model u_tic_pin_model (
		.clk_i(clk_i),
		.pin_o(pin)
	);

	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic wr(input logic [TIC_AW-1:0] a, input logic [TIC_DW-1:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic chk(input logic [TIC_AW-1:0] a, input logic [TIC_DW-1:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		tests_run++;
		if (rdata_o !== e) begin
			n_errors++;
			$display("mismatch t=%0t a=%h got %h exp %h", $time, a, rdata_o, e);
		end
	endtask : chk
	function automatic logic [31:0] cw(input tic_mode_t m, input tic_timing_t t, input logic [31:0] x);
		return 32'h1 | (32'(m) << CTRL_MODE) | (32'(t) << CTRL_TIMING) | x;
	endfunction : cw
	// Idle levels per edge settings, then start
	task automatic go(input logic [31:0] c);
		u_tic_pin_model.set(0, c[CTRL_MODE] ? c[CTRL_START_EDGE] : c[CTRL_WIDTH_EDGE]);
		u_tic_pin_model.set(1, c[CTRL_END_EDGE]);
		u_tic_pin_model.hold(5);
		wr(OFS_CTRL, c);
	endtask : go
	task automatic stim(input logic [31:0] c, input int n);
		if (c[CTRL_MODE]) begin
			u_tic_pin_model.pair(c[CTRL_START_EDGE], c[CTRL_END_EDGE], n);
		end else begin
			u_tic_pin_model.pulse(0, ~c[CTRL_WIDTH_EDGE], n);
		end
		u_tic_pin_model.hold(6);
	endtask : stim

	initial begin
		logic [31:0] c;
		clk_i = 1'b0;
		arst_n_i = 1'b0;
		ce_i = 1'b1;
		addr_i = '0;
		wdata_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		rows = '{
			'{cw(MODE_WIDTH, TIM_ON_DEMAND, '0), 5},
			'{cw(MODE_WIDTH, TIM_ON_DEMAND, 32'h1 << CTRL_WIDTH_EDGE), 7},
			'{cw(MODE_TWO_EDGE, TIM_ON_DEMAND, '0), 4},
			'{cw(MODE_TWO_EDGE, TIM_ON_DEMAND, 32'h1 << CTRL_START_EDGE), 6},
			'{cw(MODE_TWO_EDGE, TIM_ON_DEMAND, 32'h1 << CTRL_END_EDGE), 3},
			'{cw(MODE_TWO_EDGE, TIM_ON_DEMAND, 32'h3 << CTRL_START_EDGE), 9},
			'{cw(MODE_TWO_EDGE, TIM_IMPLICIT, '0), 8},
			'{cw(MODE_WIDTH, TIM_IMPLICIT, '0), 1}
		};
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		// Reset values, unmapped and read-only places
		chk(OFS_CTRL, '0);
		chk(OFS_STATUS, '0);
		chk(OFS_RESULT, '0);
		chk(4'h1, '0);
		wr(OFS_STATUS, 32'hFFFF_FFFF);
		chk(OFS_STATUS, '0);
		foreach (rows[i]) begin
			go(rows[i].c);
			stim(rows[i].c, rows[i].n);
			chk(OFS_RESULT, 32'(rows[i].n));
		end
		// Held result ignores later input until read
		for (int m = 0; m < 2; m++) begin
			c = cw(tic_mode_t'(m), TIM_ON_DEMAND, '0);
			go(c);
			stim(c, 5);
			stim(c, 7);
			chk(OFS_STATUS, 32'h3);
			chk(OFS_RESULT, 32'h5);
			stim(c, 9);
			chk(OFS_RESULT, 32'h9);
		end
		// Started while input already active
		u_tic_pin_model.set(0, 1'b1);
		u_tic_pin_model.hold(5);
		wr(OFS_CTRL, c & ~(32'h1 << CTRL_MODE));
		u_tic_pin_model.hold(10);
		u_tic_pin_model.set(0, 1'b0);
		stim(32'h1, 6);
		chk(OFS_RESULT, 32'h6);
		// Every pulse buffered
		c = cw(MODE_WIDTH, TIM_IMPLICIT, '0);
		go(c);
		for (int k = 3; k < 6; k++) stim(c, k);
		for (int k = 3; k < 6; k++) chk(OFS_RESULT, 32'(k));
		chk(OFS_RESULT, '0);
		// Nine pulses into eight places: overflow flagged
		for (int k = 0; k < 9; k++) stim(c, 2);
		chk(OFS_STATUS, 32'h7);
		// Sample clock on pin 2, second edge with no new pulse
		for (int m = 0; m < 2; m++) begin
			c = cw(tic_mode_t'(m), TIM_SAMPLE, 32'h2 << CTRL_SMP_SRC);
			go(c);
			stim(c, 4);
			stim(c, 6);
			repeat (2) begin
				u_tic_pin_model.pulse(2, 1'b1, 3);
				u_tic_pin_model.hold(6);
			end
			chk(OFS_RESULT, 32'h6);
			chk(OFS_RESULT, 32'h6);
		end
		// Arm trigger on pin 3, both polarities, input active at trigger
		for (int p = 0; p < 2; p++) begin
			c = cw(MODE_WIDTH, TIM_ON_DEMAND, 32'h1 << CTRL_ARM_EN | 32'(p) << CTRL_ARM_POL | 32'h3 << CTRL_ARM_SRC);
			u_tic_pin_model.set(3, p[0]);
			go(c);
			stim(c, 4);
			chk(OFS_STATUS, '0);
			u_tic_pin_model.set(0, 1'b1);
			u_tic_pin_model.hold(4);
			u_tic_pin_model.set(3, ~p[0]);
			u_tic_pin_model.hold(8);
			u_tic_pin_model.set(0, 1'b0);
			stim(c, 7);
			chk(OFS_RESULT, 32'h7);
		end
		// Pin 3 as timebase, a rising edge every two clocks
		c = cw(MODE_WIDTH, TIM_ON_DEMAND, 32'h3 << CTRL_TB_SRC);
		go(c);
		u_tic_pin_model.run_tb(1'b1);
		stim(c, 8);
		u_tic_pin_model.run_tb(1'b0);
		chk(OFS_RESULT, 32'h4);
		// Encoder, each decode, forward then back
		for (int d = 0; d < 3; d++) begin
			wr(OFS_CTRL, cw(MODE_QUAD, TIM_ON_DEMAND, 32'(d) << CTRL_DECODE));
			wr(OFS_COUNT, '0);
			u_tic_pin_model.quad(1'b1, 1);
			chk(OFS_COUNT, 32'h1 << d);
			u_tic_pin_model.quad(1'b0, 2);
			chk(OFS_COUNT, -(32'h1 << d));
		end
		// Clock enable low freezes pins and count
		@(posedge clk_i);
		ce_i <= 1'b0;
		u_tic_pin_model.quad(1'b1, 1);
		@(posedge clk_i);
		ce_i <= 1'b1;
		u_tic_pin_model.hold(4);
		chk(OFS_COUNT, -(32'h4));
		// Mid-run reset clears count and control
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		chk(OFS_COUNT, '0);
		chk(OFS_CTRL, '0);
		chk(OFS_STATUS, '0);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
